// file: hdl/cswc_pkg.sv
// shared constants and types for the chip-select wait control block
package cswc_pkg;

  // register map, byte offsets on the plain register port
  localparam int CSWC_ADDR_W = 8;
  localparam logic [7:0] CSWC_CTRL_OFS = 8'h00;
  localparam logic [7:0] CSWC_STAT_OFS = 8'h04;

  // control word layout, reserved bits held at zero
  localparam logic [31:0] CSWC_CTRL_MASK = 32'h0bdf_0fdf;
  localparam logic [31:0] CSWC_CTRL_RST = 32'h0005_0805;

  // region 2 fields
  localparam int CSWC_R2_WAIT_LSB = 0;
  localparam int CSWC_R2_WIDTH_BIT = 4;
  localparam int CSWC_R2_WAVE_LSB = 6;
  localparam int CSWC_R2_RCV_LSB = 8;
  localparam int CSWC_R2_SPACE_BIT = 10;
  localparam int CSWC_R2_EN_BIT = 11;

  // region 3 fields
  localparam int CSWC_R3_WAIT_LSB = 16;
  localparam int CSWC_R3_WIDTH_BIT = 20;
  localparam int CSWC_R3_WAVE_LSB = 22;
  localparam int CSWC_R3_RCV_LSB = 24;
  localparam int CSWC_R3_EN_BIT = 27;

  // status word layout
  localparam int CSWC_ST_BUSY_BIT = 0;
  localparam int CSWC_ST_REGION_BIT = 1;
  localparam int CSWC_ST_REFUSED_BIT = 2;
  localparam int CSWC_ST_WIDTH_BIT = 3;

  // field encodings
  localparam logic [3:0] CSWC_WAIT_EXT = 4'hf;
  localparam logic [2:0] CSWC_EXT_FIRST = 3'h1;
  localparam logic [1:0] CSWC_RCV_TWO = 2'h0;
  localparam logic [1:0] CSWC_RCV_ONE = 2'h1;
  localparam logic [1:0] CSWC_RCV_NONE = 2'h2;
  localparam logic [1:0] CSWC_RCV_CNT_TWO = 2'h2;
  localparam logic [1:0] CSWC_RCV_CNT_ONE = 2'h1;
  localparam logic [1:0] CSWC_RCV_CNT_NONE = 2'h0;

  // access sequencer states, gray along idle-strobe-wait-xwait-recover
  typedef enum logic [2:0] {
    CSWC_IDLE = 3'b000,
    CSWC_STROBE = 3'b001,
    CSWC_WAIT = 3'b011,
    CSWC_XWAIT = 3'b010,
    CSWC_RECOV = 3'b110
  } cswc_state_e;

  // recovery field to number of idle cycles
  function automatic logic [1:0] cswc_rcv_cycles(input logic [1:0] code);
    case (code)
      CSWC_RCV_TWO: cswc_rcv_cycles = CSWC_RCV_CNT_TWO;
      CSWC_RCV_ONE: cswc_rcv_cycles = CSWC_RCV_CNT_ONE;
      CSWC_RCV_NONE: cswc_rcv_cycles = CSWC_RCV_CNT_NONE;
      default: cswc_rcv_cycles = CSWC_RCV_CNT_NONE;
    endcase
  endfunction

endpackage

// file: hdl/cswc_timer.sv
// access sequencer: strobe, wait states, external wait and read recovery
`timescale 1ns/1ps
module cswc_timer (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // access request
  input wire logic start,
  input wire logic [3:0] wait_code,
  input wire logic [1:0] recov_code,
  input wire logic is_read,
  // external wait pin, low holds the access
  input wire logic wait_n,
  // progress
  output logic strobe_last,
  output logic finish
);
  import cswc_pkg::*;

  cswc_state_e state_r;
  cswc_state_e state_nxt;
  logic [2:0] wcnt_r;
  logic [1:0] rcnt_r;
  logic ext_r;
  logic read_r;
  logic after_rcv;

  //////////////////////////////////////////////////////////////////////
  // end of strobe and end of access

  // recovery only follows reads
  assign after_rcv = read_r && (rcnt_r != CSWC_RCV_CNT_NONE);

  always_comb begin
    strobe_last = 1'b0;
    case (state_r)
      CSWC_STROBE: strobe_last = (wcnt_r == 3'h0);
      CSWC_WAIT: strobe_last = (wcnt_r == 3'h1) && !(ext_r && !wait_n);
      CSWC_XWAIT: strobe_last = wait_n;
      default: strobe_last = 1'b0;
    endcase
  end

  always_comb begin
    finish = 1'b0;
    if (strobe_last && !after_rcv) begin
      finish = 1'b1;
    end else if (state_r == CSWC_RECOV && rcnt_r == CSWC_RCV_CNT_ONE) begin
      finish = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // state machine

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      CSWC_IDLE: begin
        if (start) begin
          state_nxt = CSWC_STROBE;
        end
      end
      CSWC_STROBE: begin
        if (wcnt_r != 3'h0) begin
          state_nxt = CSWC_WAIT;
        end
      end
      CSWC_WAIT: begin
        if (wcnt_r == 3'h1 && ext_r && !wait_n) begin
          state_nxt = CSWC_XWAIT;
        end
      end
      CSWC_XWAIT: state_nxt = CSWC_XWAIT;
      CSWC_RECOV: state_nxt = CSWC_RECOV;
      default: state_nxt = CSWC_IDLE;
    endcase
    if (strobe_last) begin
      state_nxt = after_rcv ? CSWC_RECOV : CSWC_IDLE;
    end
    if (state_r == CSWC_RECOV && finish) begin
      state_nxt = CSWC_IDLE;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= CSWC_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // wait and recovery counters, latched at start

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wcnt_r <= 3'h0;
      ext_r <= 1'b0;
    end else if (start && state_r == CSWC_IDLE) begin
      ext_r <= (wait_code == CSWC_WAIT_EXT);
      wcnt_r <= (wait_code == CSWC_WAIT_EXT) ? CSWC_EXT_FIRST : wait_code[2:0];
    end else if (state_r == CSWC_WAIT && wcnt_r != 3'h1) begin
      wcnt_r <= wcnt_r - 3'h1;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rcnt_r <= CSWC_RCV_CNT_NONE;
      read_r <= 1'b0;
    end else if (start && state_r == CSWC_IDLE) begin
      rcnt_r <= cswc_rcv_cycles(recov_code);
      read_r <= is_read;
    end else if (state_r == CSWC_RECOV) begin
      rcnt_r <= rcnt_r - CSWC_RCV_CNT_ONE;
    end
  end

endmodule

// file: hdl/cswc_top.sv
// chip-select wait control for regions 2 and 3, with its control register
// What this block does
// - wait field 0000 to 0111 inserts that many fixed wait states.
// - wait field 1111 inserts one wait plus as many as wait pin holds.
// - two-bit recovery field sets idle cycles after a read, 00 gives two.
// - region 2 space select, 0 decodes the whole space.
// - per-region width bit, 0 is 16-bit, 1 is 8-bit accesses.
// - recovery 00 two, 01 one, 10 none, 11 reserved.
// - region enable bit, 0 blocks chip select, 1 allows accesses.
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module cswc_top (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // register port
  input wire logic [cswc_pkg::CSWC_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  // processor access request
  input wire logic acc_start,
  input wire logic acc_region3,
  input wire logic acc_upper,
  input wire logic acc_read,
  // external memory side
  input wire logic wait_n,
  output logic cs2_n,
  output logic cs3_n,
  output logic bus_8bit,
  // access status
  output logic acc_busy,
  output logic acc_done,
  output logic acc_refused
);
  import cswc_pkg::*;

  logic [31:0] ctrl_r;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic cs2_n_r;
  logic cs3_n_r;
  logic width_r;
  logic busy_r;
  logic done_r;
  logic refused_r;
  logic region_r;
  logic hit2;
  logic hit3;
  logic hit;
  logic accept;
  logic [3:0] sel_wait;
  logic [1:0] sel_rcv;
  logic sel_width;
  logic strobe_last;
  logic finish;

  // pick a region field from the control word
  function automatic logic [3:0] cswc_pick4(input logic r3, input logic [31:0] w,
                                            input int lsb2, input int lsb3);
    cswc_pick4 = r3 ? w[lsb3 +: 4] : w[lsb2 +: 4];
  endfunction

  // two-bit field of the selected region
  function automatic logic [1:0] cswc_pick2(input logic r3, input logic [31:0] w,
    input int lsb2, input int lsb3);
    cswc_pick2 = r3 ? w[lsb3 +: 2] : w[lsb2 +: 2];
  endfunction

  // one-bit field of the selected region
  function automatic logic cswc_pick1(input logic r3, input logic [31:0] w,
    input int pos2, input int pos3);
    cswc_pick1 = r3 ? w[pos3] : w[pos2];
  endfunction

  // register select, shared by the write and read paths
  function automatic logic cswc_sel(input logic [CSWC_ADDR_W-1:0] a,
    input logic [CSWC_ADDR_W-1:0] ofs);
    cswc_sel = (a == ofs);
  endfunction

  // status word as software sees it
  function automatic logic [31:0] cswc_status(input logic busy, input logic region,
    input logic refused, input logic width);
    cswc_status = 32'h0000_0000;
    cswc_status[CSWC_ST_BUSY_BIT] = busy;
    cswc_status[CSWC_ST_REGION_BIT] = region;
    cswc_status[CSWC_ST_REFUSED_BIT] = refused;
    cswc_status[CSWC_ST_WIDTH_BIT] = width;
  endfunction

  //////////////////////////////////////////////////////////////////////
  // control register

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r <= CSWC_CTRL_RST;
    end else if (reg_write && cswc_sel(reg_addr, CSWC_CTRL_OFS)) begin
      // reserved codes are stored as written, their effect is defined below
      ctrl_r <= reg_wdata & CSWC_CTRL_MASK;
    end
  end

  // read mux, unmapped addresses and idle cycles read zero
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (reg_read && cswc_sel(reg_addr, CSWC_CTRL_OFS)) begin
      rdata_nxt = ctrl_r;
    end else if (reg_read && cswc_sel(reg_addr, CSWC_STAT_OFS)) begin
      rdata_nxt = cswc_status(busy_r, region_r, refused_r, width_r);
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // region decode

  assign hit2 = ctrl_r[CSWC_R2_EN_BIT] && (!ctrl_r[CSWC_R2_SPACE_BIT] || !acc_upper);
  assign hit3 = ctrl_r[CSWC_R3_EN_BIT];
  assign hit = acc_region3 ? hit3 : hit2;
  // a request while busy is dropped; the master must wait for done
  assign accept = acc_start && !busy_r && hit;

  // wait code as stored
  // codes 1000 to 1110 run as their low three bits
  assign sel_wait = cswc_pick4(acc_region3, ctrl_r, CSWC_R2_WAIT_LSB, CSWC_R3_WAIT_LSB);
  assign sel_rcv = cswc_pick2(acc_region3, ctrl_r, CSWC_R2_RCV_LSB, CSWC_R3_RCV_LSB);
  assign sel_width = cswc_pick1(acc_region3, ctrl_r, CSWC_R2_WIDTH_BIT, CSWC_R3_WIDTH_BIT);

  // waveform field unused
  // only the rom/ram waveform exists, so the waveform bits steer nothing

  //////////////////////////////////////////////////////////////////////
  // sequencer

  cswc_timer u_timer (
    .clock(clock),
    .reset_n(reset_n),
    .start(accept),
    .wait_code(sel_wait),
    .recov_code(sel_rcv),
    .is_read(acc_read),
    .wait_n(wait_n),
    .strobe_last(strobe_last),
    .finish(finish)
  );

  //////////////////////////////////////////////////////////////////////
  // chip selects and status

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cs2_n_r <= 1'b1;
      cs3_n_r <= 1'b1;
    end else if (accept) begin
      cs2_n_r <= acc_region3;
      cs3_n_r <= !acc_region3;
    end else if (strobe_last) begin
      cs2_n_r <= 1'b1;
      cs3_n_r <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      width_r <= 1'b0;
      region_r <= 1'b0;
    end else if (accept) begin
      width_r <= sel_width;
      region_r <= acc_region3;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      busy_r <= 1'b0;
    end else if (accept) begin
      busy_r <= 1'b1;
    end else if (finish) begin
      busy_r <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      done_r <= 1'b0;
    end else begin
      done_r <= busy_r && finish;
    end
  end

  // refusal is a one-cycle pulse, so there is no set and clear race
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      refused_r <= 1'b0;
    end else begin
      refused_r <= acc_start && !busy_r && !hit;
    end
  end

  assign reg_rdata = rdata_r;
  assign cs2_n = cs2_n_r;
  assign cs3_n = cs3_n_r;
  assign bus_8bit = width_r;
  assign acc_busy = busy_r;
  assign acc_done = done_r;
  assign acc_refused = refused_r;

endmodule

// file: tb/cswc_mem.sv
// external memory model that holds the wait pin low for a set number of cycles
`timescale 1ns/1ps
module cswc_mem (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // chip selects from the block
  input wire logic cs2_n,
  input wire logic cs3_n,
  // extra wait cycles this device asks for
  input wire logic [3:0] hold,
  // wait pin, pulled up when released
  output logic wait_n
);
  logic [4:0] k_r;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      k_r <= 5'h00;
    end else if (cs2_n && cs3_n) begin
      k_r <= 5'h00;
    end else begin
      k_r <= k_r + 5'h01;
    end
  end
  // hold from first wait
  // released outside a frame, so the pull-up wins
  assign wait_n = !(k_r >= 5'h01 && k_r < 5'h01 + {1'b0, hold});
endmodule

// file: tb/cswc_props.sv
// concurrent checks on the chip-select wait control ports
`timescale 1ns/1ps
module cswc_props (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // register writes
  input wire logic [cswc_pkg::CSWC_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  // access side
  input wire logic acc_start,
  input wire logic wait_n,
  input wire logic cs2_n,
  input wire logic cs3_n,
  input wire logic acc_busy,
  input wire logic acc_done,
  input wire logic acc_refused
);
  import cswc_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  logic [3:0] w2_r;
  logic [4:0] n2_r;
  // shadow of the region 2 wait field, seen only through writes
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      w2_r <= CSWC_CTRL_RST[3:0];
    end else if (reg_write && reg_addr == CSWC_CTRL_OFS) begin
      w2_r <= reg_wdata[3:0];
    end
  end
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      n2_r <= 5'h00;
    end else begin
      n2_r <= cs2_n ? 5'h00 : n2_r + 5'h01;
    end
  end
  sequence s_ext_low;
    (w2_r == CSWC_WAIT_EXT && !cs2_n) ##1 (!cs2_n && !wait_n);
  endsequence
  sequence s_ext_free;
    (w2_r == CSWC_WAIT_EXT && !cs2_n) ##1 (!cs2_n && wait_n);
  endsequence
  fixed_len_a: assert property ($rose(cs2_n) && !w2_r[3] |-> n2_r == {1'b0, w2_r} + 5'h01)
    else $error("fixed wait length wrong");
  ext_hold_a: assert property (s_ext_low |=> !cs2_n)
    else $error("access ended while wait held");
  ext_end_a: assert property (s_ext_free |=> cs2_n)
    else $error("access ran on after wait freed");
  cs_excl_a: assert property (cs2_n || cs3_n)
    else $error("both chip selects low");
  cs_busy_a: assert property (!(cs2_n && cs3_n) |-> acc_busy)
    else $error("chip select low while idle");
  cs_cause_a: assert property ($fell(cs2_n) || $fell(cs3_n) |-> $past(acc_start))
    else $error("chip select without start");
  refuse_cause_a: assert property (acc_refused |-> $past(acc_start) && cs2_n && cs3_n)
    else $error("refusal without start");
  done_end_a: assert property (acc_done |-> !acc_busy && $past(acc_busy))
    else $error("done not at end of busy");
  done_pulse_a: assert property (acc_done |=> !acc_done)
    else $error("done longer than a cycle");
endmodule

// file: tb/cswc_top_bench.sv
// self-checking bench for the chip-select wait control block
`timescale 1ns/1ps
module cswc_top_bench;
  import cswc_pkg::*;
  logic clock, reset_n, reg_write, reg_read, acc_start, acc_region3, acc_upper, acc_read;
  logic wait_n, cs2_n, cs3_n, bus_8bit, acc_busy, acc_done, acc_refused;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, q;
  logic [3:0] hold;
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;
  localparam logic [31:0] EN2 = 32'h0000_0a00;
  localparam logic [31:0] EN3 = 32'h0a00_0000;
  cswc_top uut (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .acc_start(acc_start),
    .acc_region3(acc_region3), .acc_upper(acc_upper), .acc_read(acc_read), .wait_n(wait_n),
    .cs2_n(cs2_n), .cs3_n(cs3_n), .bus_8bit(bus_8bit), .acc_busy(acc_busy),
    .acc_done(acc_done), .acc_refused(acc_refused));
  cswc_mem mem (.clock(clock), .reset_n(reset_n), .cs2_n(cs2_n), .cs3_n(cs3_n),
    .hold(hold), .wait_n(wait_n));
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // program, start one access, count chip-select and busy cycles up to done
  task automatic run(input logic [31:0] cfg, input logic r3, input logic up, input logic rdq,
      input int ecs, input int eb);
    int ncs;
    int nb;
    logic refd;
    ncs = 0;
    nb = 0;
    refd = 1'b0;
    wr(CSWC_CTRL_OFS, cfg);
    @(posedge clock);
    acc_start <= 1'b1;
    acc_region3 <= r3;
    acc_upper <= up;
    acc_read <= rdq;
    @(posedge clock);
    acc_start <= 1'b0;
    for (int i = 0; i < 40; i++) begin
      #1;
      if (acc_refused === 1'b1) refd = 1'b1;
      if (acc_done === 1'b1 || refd) break;
      if ((r3 ? cs3_n : cs2_n) === 1'b0) ncs++;
      if (acc_busy === 1'b1) nb++;
      @(posedge clock);
    end
    chk(32'(ncs), 32'(ecs));
    chk(32'(nb), 32'(eb));
    chk({31'h0, refd}, {31'h0, ecs == 0});
  endtask
  initial begin
    {reset_n, reg_write, reg_read, acc_start, acc_region3, acc_upper, acc_read} = 7'h00;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    hold = 4'h0;
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    rd(CSWC_CTRL_OFS, q);
    chk(q, CSWC_CTRL_RST);
    wr(CSWC_CTRL_OFS, 32'hff3f_ff3f);
    rd(CSWC_CTRL_OFS, q);
    chk(q, CSWC_CTRL_MASK & 32'hff3f_ff3f);
    wr(8'h40, 32'hffff_ffff);
    rd(8'h40, q);
    chk(q, 32'h0);
    $display("test registers done");
    for (int w = 0; w < 8; w++) begin
      run(EN2 | 32'(w), 1'b0, 1'b0, 1'b0, w + 1, w + 1);
      run(EN3 | 32'(w << 16), 1'b1, 1'b0, 1'b0, w + 1, w + 1);
    end
    $display("test fixed waits done");
    for (int r = 0; r < 3; r++) begin
      run(32'h0000_0801 | 32'(r << 8), 1'b0, 1'b0, 1'b1, 2, 4 - r);
      run(32'h0801_0000 | 32'(r << 24), 1'b1, 1'b0, 1'b1, 2, 4 - r);
    end
    $display("test recovery done");
    for (int n = 0; n < 4; n += 3) begin
      hold = 4'(n);
      run(EN2 | 32'hf, 1'b0, 1'b0, 1'b0, 2 + n, 2 + n);
      run(EN3 | 32'h000f_0000, 1'b1, 1'b0, 1'b0, 2 + n, 2 + n);
    end
    hold = 4'h0;
    $display("test external wait done");
    run(32'h0000_0200, 1'b0, 1'b0, 1'b0, 0, 0);
    run(EN2, 1'b1, 1'b0, 1'b0, 0, 0);
    run(EN2 | 32'h400, 1'b0, 1'b1, 1'b0, 0, 0);
    run(EN2 | 32'h400, 1'b0, 1'b0, 1'b0, 1, 1);
    run(EN2, 1'b0, 1'b1, 1'b0, 1, 1);
    $display("test enable and space done");
    run(EN2 | 32'h10, 1'b0, 1'b0, 1'b0, 1, 1);
    chk({31'h0, bus_8bit}, 32'h1);
    run(EN2, 1'b0, 1'b0, 1'b0, 1, 1);
    chk({31'h0, bus_8bit}, 32'h0);
    run(EN3 | 32'h0010_0000, 1'b1, 1'b0, 1'b0, 1, 1);
    chk({31'h0, bus_8bit}, 32'h1);
    rd(CSWC_STAT_OFS, q);
    chk(q, (32'h1 << CSWC_ST_WIDTH_BIT) | (32'h1 << CSWC_ST_REGION_BIT));
    $display("test bus width done");
    end_of_test();
  end
endmodule
bind cswc_top cswc_props chk (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .acc_start(acc_start), .wait_n(wait_n),
  .cs2_n(cs2_n), .cs3_n(cs3_n), .acc_busy(acc_busy), .acc_done(acc_done),
  .acc_refused(acc_refused));
